// *** src/sfc_pkg.sv ***
// Shared constants and types of the switch output controller
package sfc_pkg;

  // Bus widths
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned STRB_W = 4;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_ON_VAL  = 8'h04;
  localparam logic [7:0] REG_OFF_VAL = 8'h08;
  localparam logic [7:0] REG_ON_DLY  = 8'h0c;
  localparam logic [7:0] REG_OFF_DLY = 8'h10;
  localparam logic [7:0] REG_STATUS  = 8'h14;

  // Control register field positions
  localparam int unsigned CTRL_FUNC_LSB  = 0;
  localparam int unsigned CTRL_DCLS_LSB  = 4;
  localparam int unsigned CTRL_DSRC_LSB  = 6;
  localparam int unsigned CTRL_LVAR_LSB  = 8;
  localparam int unsigned CTRL_FMODE_LSB = 12;
  localparam int unsigned CTRL_INV_BIT   = 16;

  // Status register bit positions
  localparam int unsigned STAT_SW_BIT   = 0;
  localparam int unsigned STAT_LIM_BIT  = 1;
  localparam int unsigned STAT_ERR_BIT  = 2;
  localparam int unsigned STAT_PEND_BIT = 3;

  // Function modes
  typedef enum logic [2:0] {
    FUNC_OFF = 3'h0, FUNC_ON = 3'h1, FUNC_DIAG = 3'h2,
    FUNC_LIMIT = 3'h3, FUNC_DIGITAL = 3'h4
  } sfc_func_t;

  // Diagnostic class, digital source, failure state
  typedef enum logic [1:0] {
    DCLS_ALARM = 2'h0, DCLS_ALARM_WARN = 2'h1, DCLS_WARN = 2'h2
  } sfc_dcls_t;
  typedef enum logic [1:0] {
    DSRC_NONE = 2'h0, DSRC_AD1 = 2'h1, DSRC_AD2 = 2'h2
  } sfc_dsrc_t;
  typedef enum logic [1:0] {
    FMODE_ACTUAL = 2'h0, FMODE_OPEN = 2'h1, FMODE_CLOSED = 2'h2
  } sfc_fmode_t;

  // Limit variable codes; zero means none assigned
  localparam logic [3:0] LVAR_NONE = 4'h0;
  localparam logic [3:0] LVAR_MAX  = 4'hc;

  // Reset values
  localparam logic [2:0] FUNC_RST  = 3'h0;
  localparam logic [1:0] DCLS_RST  = 2'h0;
  localparam logic [1:0] DSRC_RST  = 2'h0;
  localparam logic [1:0] FMODE_RST = 2'h1;
  localparam logic [31:0] THR_RST  = 32'h0000_0000;

  // Timing: 0.1 s delay tick at a 20 MHz clock
  localparam int unsigned CLK_HZ      = 20_000_000;
  localparam int unsigned TICK_MS     = 100;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned DLY_MAX_S   = 100;
  localparam int unsigned DLY_MAX     = DLY_MAX_S * 1000 / TICK_MS;
  localparam int unsigned DLY_W       = 10;
  localparam logic [DLY_W-1:0] DLY_RST = 10'h000;

  // Complete state of the controller
  typedef struct packed {
    logic [2:0]        func;
    logic [1:0]        dcls;
    logic [1:0]        dsrc;
    logic [3:0]        lvar;
    logic [1:0]        fmode;
    logic              inv;
    logic [31:0]       on_val;
    logic [31:0]       off_val;
    logic [DLY_W-1:0]  on_dly;
    logic [DLY_W-1:0]  off_dly;
    logic              lim_req;
    logic              lim_st;
    logic [DLY_W-1:0]  cnt;
    logic              sw;
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
  } sfc_state_t;

endpackage : sfc_pkg

// *** src/sfc_tick.sv ***
// Timebase divider giving a one-cycle delay tick
`timescale 1ns/100ps
module sfc_tick #(
  parameter int unsigned DIV = 2
) (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  output logic      tick_o
);
  localparam int unsigned CW = (DIV > 2) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          tick;
  } sfc_tick_state_t;

  sfc_tick_state_t r_reg;
  sfc_tick_state_t r_next;

  // Free-running count, pulse on wrap
  always_comb begin
    r_next      = r_reg;
    r_next.tick = 1'b0;
    if (r_reg.cnt == LAST) begin
      r_next.cnt  = '0;
      r_next.tick = 1'b1;
    end else begin
      r_next.cnt = r_reg.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign tick_o = r_reg.tick;

endmodule : sfc_tick

// *** src/sfc_fcmp.sv ***
// Comparator for two single-precision floating-point values
`timescale 1ns/100ps
module sfc_fcmp (
  input  wire logic [31:0] a_i,
  input  wire logic [31:0] b_i,
  output logic             gt_o,
  output logic             lt_o
);
  // Map to an order-preserving unsigned key; both zeros equal
  function automatic logic [31:0] key(input logic [31:0] x);
    logic [31:0] k;
    k = '0;
    if (x[30:0] == 31'h0) begin
      k = 32'h8000_0000;
    end else if (x[31]) begin
      k = ~x;
    end else begin
      k = {1'b1, x[30:0]};
    end
    return k;
  endfunction : key

  function automatic logic is_nan(input logic [31:0] x);
    return (x[30:23] == 8'hff) && (x[22:0] != 23'h0);
  endfunction : is_nan

  logic ok;
  logic [31:0] ka;
  logic [31:0] kb;

  // A NaN on either side makes both results false
  always_comb begin
    ok   = !is_nan(a_i) && !is_nan(b_i);
    ka   = key(a_i);
    kb   = key(b_i);
    gt_o = ok && (ka > kb);
    lt_o = ok && (ka < kb);
  end

endmodule : sfc_fcmp

// *** src/sfc_switch_ctrl.sv ***
// Switch output controller: registers, mode logic, limit delays
`timescale 1ns/100ps
module sfc_switch_ctrl #(
  parameter int unsigned TICK_CYCLES = sfc_pkg::TICK_CYCLES
) (
  input  wire logic                        clk_i,
  input  wire logic                        rstn_i,
  input  wire logic                        psel_i,
  input  wire logic                        penable_i,
  input  wire logic                        pwrite_i,
  input  wire logic [sfc_pkg::ADDR_W-1:0]  paddr_i,
  input  wire logic [sfc_pkg::DATA_W-1:0]  pwdata_i,
  input  wire logic [sfc_pkg::STRB_W-1:0]  pstrb_i,
  output logic      [sfc_pkg::DATA_W-1:0]  prdata_o,
  output logic                             pready_o,
  output logic                             pslverr_o,
  input  wire logic                        diag_alarm_i,
  input  wire logic                        diag_warn_i,
  input  wire logic                        error_i,
  input  wire logic                        ad_sw1_i,
  input  wire logic                        ad_sw2_i,
  input  wire logic                        pv_valid_i,
  input  wire logic [3:0]                  pv_id_i,
  input  wire logic [31:0]                 pv_value_i,
  output logic                             switch_closed_o
);
  import sfc_pkg::*;

  localparam logic [DLY_W-1:0] DLY_LIMIT = DLY_W'(DLY_MAX);

  sfc_state_t r_reg;
  sfc_state_t r_next;

  logic tick;
  logic v_gt_on;
  logic v_lt_on;
  logic v_gt_off;
  logic v_lt_off;
  logic on_lt_off;

  // Delay timebase
  sfc_tick #(
    .DIV (TICK_CYCLES)
  ) u_tick (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .tick_o (tick)
  );

  // Sample against both thresholds, thresholds against each other
  sfc_fcmp u_cmp_on (
    .a_i  (pv_value_i),
    .b_i  (r_reg.on_val),
    .gt_o (v_gt_on),
    .lt_o (v_lt_on)
  );

  sfc_fcmp u_cmp_off (
    .a_i  (pv_value_i),
    .b_i  (r_reg.off_val),
    .gt_o (v_gt_off),
    .lt_o (v_lt_off)
  );

  sfc_fcmp u_cmp_thr (
    .a_i  (r_reg.on_val),
    .b_i  (r_reg.off_val),
    .gt_o (),
    .lt_o (on_lt_off)
  );

  // Byte-lane merge of write data
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] wd,
    input logic [3:0]  be
  );
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return m;
  endfunction : merge

  // Clamp a written delay to the legal range
  function automatic logic [DLY_W-1:0] clamp(input logic [31:0] w);
    logic [DLY_W-1:0] d;
    d = DLY_LIMIT;
    if (w < 32'(DLY_MAX)) begin
      d = w[DLY_W-1:0];
    end
    return d;
  endfunction : clamp

  logic        setup;
  logic        wr;
  logic        smp;
  logic        hit;
  logic [31:0] ctrl_rd;
  logic [31:0] stat_rd;
  logic [31:0] ctrl_w;
  logic        evt;
  logic        comp;
  logic        fin;
  logic [DLY_W-1:0] dsel;

  // Register readback images
  always_comb begin
    ctrl_rd = '0;
    ctrl_rd[CTRL_FUNC_LSB  +: 3] = r_reg.func;
    ctrl_rd[CTRL_DCLS_LSB  +: 2] = r_reg.dcls;
    ctrl_rd[CTRL_DSRC_LSB  +: 2] = r_reg.dsrc;
    ctrl_rd[CTRL_LVAR_LSB  +: 4] = r_reg.lvar;
    ctrl_rd[CTRL_FMODE_LSB +: 2] = r_reg.fmode;
    ctrl_rd[CTRL_INV_BIT]        = r_reg.inv;
    stat_rd = '0;
    stat_rd[STAT_SW_BIT]   = r_reg.sw;
    stat_rd[STAT_LIM_BIT]  = r_reg.lim_st;
    stat_rd[STAT_ERR_BIT]  = error_i;
    stat_rd[STAT_PEND_BIT] = r_reg.lim_req != r_reg.lim_st;
    ctrl_w = merge(ctrl_rd, pwdata_i, pstrb_i);
  end

  // Bus decode, limit tracking and output selection
  always_comb begin
    r_next         = r_reg;
    setup          = psel_i && !penable_i && !r_reg.pready;
    wr             = psel_i && penable_i && r_reg.pready && pwrite_i;
    smp            = pv_valid_i && (r_reg.lvar != LVAR_NONE)
                     && (pv_id_i == r_reg.lvar);
    hit            = 1'b1;
    evt            = 1'b0;
    comp           = 1'b0;
    fin            = 1'b0;
    dsel           = r_reg.lim_req ? r_reg.on_dly : r_reg.off_dly;
    r_next.pready  = setup;

    // Read data and error answer at the setup cycle
    if (setup) begin
      unique case (paddr_i)
        REG_CTRL:    r_next.prdata = ctrl_rd;
        REG_ON_VAL:  r_next.prdata = r_reg.on_val;
        REG_OFF_VAL: r_next.prdata = r_reg.off_val;
        REG_ON_DLY:  r_next.prdata = 32'(r_reg.on_dly);
        REG_OFF_DLY: r_next.prdata = 32'(r_reg.off_dly);
        REG_STATUS:  r_next.prdata = stat_rd;
        default: begin
          r_next.prdata = '0;
          hit           = 1'b0;
        end
      endcase
      r_next.pslverr = !hit;
    end else begin
      r_next.pslverr = 1'b0;  // Error stands with pready only
    end

    // Writes take effect at the access edge
    if (wr) begin
      unique case (paddr_i)
        REG_CTRL: begin
          r_next.func  = ctrl_w[CTRL_FUNC_LSB  +: 3];
          r_next.dcls  = ctrl_w[CTRL_DCLS_LSB  +: 2];
          r_next.dsrc  = ctrl_w[CTRL_DSRC_LSB  +: 2];
          r_next.lvar  = ctrl_w[CTRL_LVAR_LSB  +: 4];
          r_next.fmode = ctrl_w[CTRL_FMODE_LSB +: 2];
          r_next.inv   = ctrl_w[CTRL_INV_BIT];
        end
        REG_ON_VAL: begin
          r_next.on_val = merge(r_reg.on_val, pwdata_i, pstrb_i);
        end
        REG_OFF_VAL: begin
          r_next.off_val = merge(r_reg.off_val, pwdata_i, pstrb_i);
        end
        REG_ON_DLY: begin
          r_next.on_dly = clamp(merge(32'(r_reg.on_dly), pwdata_i,
                                      pstrb_i));
        end
        REG_OFF_DLY: begin
          r_next.off_dly = clamp(merge(32'(r_reg.off_dly), pwdata_i,
                                       pstrb_i));
        end
        default: begin
          r_next.prdata = r_reg.prdata;
        end
      endcase
    end

    // Hysteresis evaluated once per matching sample
    if (smp) begin
      if (!on_lt_off) begin
        if (v_gt_on) begin
          r_next.lim_req = 1'b1;
        end else if (v_lt_off) begin
          r_next.lim_req = 1'b0;
        end
      end else begin
        if (v_lt_on) begin
          r_next.lim_req = 1'b1;
        end else if (v_gt_off) begin
          r_next.lim_req = 1'b0;
        end
      end
    end

    // Pending change counted in ticks, cancelled on revert
    if (r_reg.lim_req == r_reg.lim_st) begin
      r_next.cnt = '0;
    end else if (r_reg.cnt >= dsel) begin
      r_next.lim_st = r_reg.lim_req;
      r_next.cnt    = '0;
    end else if (tick) begin
      r_next.cnt = r_reg.cnt + 1'b1;
    end

    // Diagnostic event of the chosen class
    unique case (r_reg.dcls)
      DCLS_ALARM_WARN: evt = diag_alarm_i || diag_warn_i;
      DCLS_WARN:       evt = diag_warn_i;
      default:         evt = diag_alarm_i;
    endcase

    // Mode logic before failure and inversion
    unique case (r_reg.func)
      FUNC_ON:   comp = 1'b1;
      FUNC_DIAG: comp = !evt;
      FUNC_LIMIT: begin
        comp = (r_reg.lvar != LVAR_NONE) && r_reg.lim_st;
      end
      FUNC_DIGITAL: begin
        unique case (r_reg.dsrc)
          DSRC_AD1: comp = ad_sw1_i;
          DSRC_AD2: comp = ad_sw2_i;
          default:  comp = 1'b0;
        endcase
      end
      default: comp = 1'b0;
    endcase

    // Failure override in limit and digital modes
    fin = comp;
    if (error_i && ((r_reg.func == FUNC_LIMIT)
        || (r_reg.func == FUNC_DIGITAL))) begin
      unique case (r_reg.fmode)
        FMODE_ACTUAL: fin = comp;
        FMODE_CLOSED: fin = 1'b1;
        default:      fin = 1'b0;
      endcase
    end

    r_next.sw = fin ^ r_reg.inv;
  end

  // State register with documented defaults
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      r_reg         <= '0;
      r_reg.func    <= FUNC_RST;
      r_reg.dcls    <= DCLS_RST;
      r_reg.dsrc    <= DSRC_RST;
      r_reg.lvar    <= LVAR_NONE;
      r_reg.fmode   <= FMODE_RST;
      r_reg.inv     <= 1'b0;
      r_reg.on_val  <= THR_RST;
      r_reg.off_val <= THR_RST;
      r_reg.on_dly  <= DLY_RST;
      r_reg.off_dly <= DLY_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign prdata_o        = r_reg.prdata;
  assign pready_o        = r_reg.pready;
  assign pslverr_o       = r_reg.pslverr;
  assign switch_closed_o = r_reg.sw;

  // Checks on the behaviour above
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_setup;
    psel_i && !penable_i && !pready_o;
  endsequence
  sequence s_access;
    psel_i && penable_i && pready_o;
  endsequence

  a_forced_open: assert property (
    r_reg.func == FUNC_OFF && !r_reg.inv |=> !switch_closed_o)
    else $error("switch closed while forced open");

  a_forced_closed: assert property (
    r_reg.func == FUNC_ON && !r_reg.inv |=> switch_closed_o)
    else $error("switch open while forced closed");

  a_diag_open: assert property (
    r_reg.func == FUNC_DIAG && r_reg.dcls == DCLS_WARN && !r_reg.inv
    |=> switch_closed_o == !$past(diag_warn_i))
    else $error("diagnostic mode ignores warning class");

  a_digital_follow: assert property (
    r_reg.func == FUNC_DIGITAL && r_reg.dsrc == DSRC_AD2 && !error_i
    && !r_reg.inv |=> switch_closed_o == $past(ad_sw2_i))
    else $error("switch does not follow source two");

  a_hyst_close: assert property (
    smp && !on_lt_off && v_gt_on |=> r_reg.lim_req)
    else $error("value above switch-on did not request close");

  a_hyst_inverse: assert property (
    smp && on_lt_off && !v_lt_on && v_gt_off |=> !r_reg.lim_req)
    else $error("value above switch-off did not request open");

  a_delay_hold: assert property (
    $changed(r_reg.lim_st) |-> $past(r_reg.cnt) >= $past(dsel)
    && $past(r_reg.lim_req) == r_reg.lim_st)
    else $error("limit state changed before delay expired");

  a_fail_closed: assert property (
    error_i && r_reg.func == FUNC_LIMIT && r_reg.fmode == FMODE_CLOSED
    && !r_reg.inv |=> switch_closed_o)
    else $error("failure state closed not applied");

  a_invert_swap: assert property (
    r_reg.func == FUNC_ON && r_reg.inv |=> !switch_closed_o)
    else $error("invert did not swap forced closed");

  a_status_read: assert property (
    s_setup and (!pwrite_i && paddr_i == REG_STATUS)
    |=> s_access and (prdata_o[STAT_SW_BIT] == $past(switch_closed_o)))
    else $error("status does not report switch state");

  a_delay_bound: assert property (
    r_reg.cnt <= DLY_LIMIT)
    else $error("delay count ran past its limit");

endmodule : sfc_switch_ctrl

// *** verif/sfc_load_model.sv ***
// Behavioural load on the far side of the switch contact
`timescale 1ns/100ps
module sfc_load_model (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       contact_closed_i,
  output logic            load_on_o,
  output logic [7:0]      close_cnt_o
);
  logic prev_reg;
  // Current flows only while the contact conducts
  assign load_on_o = contact_closed_i;
  // Count closures so chatter on the contact shows up
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      prev_reg    <= 1'b0;
      close_cnt_o <= 8'h00;
    end else begin
      prev_reg <= contact_closed_i;
      if (contact_closed_i && !prev_reg) begin
        close_cnt_o <= close_cnt_o + 8'h01;
      end
    end
  end
endmodule : sfc_load_model

// *** verif/sfc_switch_ctrl_tb.sv ***
// Self-checking bench of the switch output controller
`timescale 1ns/100ps
module sfc_switch_ctrl_tb;
  import sfc_pkg::*;
  typedef struct packed {
    logic [31:0] ctrl;
    logic [4:0]  ins;
    logic        exp;
  } sfc_row_t;
  typedef struct packed {
    logic [31:0] on;
    logic [31:0] off;
    logic [3:0]  id;
    logic [31:0] v;
    logic        exp;
  } sfc_lrow_t;
  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [7:0]  paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic [4:0]  ins = 5'h00;
  logic        pv_valid_i = 1'b0;
  logic [3:0]  pv_id_i = 4'h0;
  logic [31:0] pv_value_i = 32'h0;
  logic        switch_closed_o;
  logic        load_on;
  logic [7:0]  close_cnt;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  cnt0;
  int          error_cnt = 0;
  int          check_count = 0;
  int          cyc = 0;
  // Mode table: ctrl word, {alarm,warn,err,ad1,ad2}, expected contact
  sfc_row_t rows [21] = '{
    '{32'h1000, 5'h16, 1'b0}, '{32'h1001, 5'h16, 1'b1},
    '{32'h11000, 5'h00, 1'b1}, '{32'h1002, 5'h00, 1'b1},
    '{32'h1002, 5'h10, 1'b0}, '{32'h1002, 5'h08, 1'b1},
    '{32'h1012, 5'h08, 1'b0}, '{32'h1012, 5'h10, 1'b0},
    '{32'h1022, 5'h08, 1'b0}, '{32'h1022, 5'h10, 1'b1},
    '{32'h1004, 5'h03, 1'b0}, '{32'h1044, 5'h02, 1'b1},
    '{32'h1044, 5'h01, 1'b0}, '{32'h1084, 5'h01, 1'b1},
    '{32'h1044, 5'h06, 1'b0}, '{32'h0044, 5'h06, 1'b1},
    '{32'h2044, 5'h04, 1'b1}, '{32'h2002, 5'h04, 1'b1},
    '{32'h11002, 5'h10, 1'b1}, '{32'h11001, 5'h00, 1'b0},
    '{32'h2103, 5'h04, 1'b1}};
  // Limit table: on, off, sample id, value, expected contact
  sfc_lrow_t lrows [8] = '{
    '{32'h40a00000, 32'h3f800000, 4'h1, 32'h40c00000, 1'b1},
    '{32'h40a00000, 32'h3f800000, 4'h1, 32'h40400000, 1'b1},
    '{32'h40a00000, 32'h3f800000, 4'h2, 32'h3f000000, 1'b1},
    '{32'h40a00000, 32'h3f800000, 4'h1, 32'h3f000000, 1'b0},
    '{32'h40a00000, 32'h3f800000, 4'h1, 32'h40400000, 1'b0},
    '{32'h3f800000, 32'h40a00000, 4'h1, 32'h3f000000, 1'b1},
    '{32'h3f800000, 32'h40a00000, 4'h1, 32'h40400000, 1'b1},
    '{32'h3f800000, 32'h40a00000, 4'h1, 32'h40c00000, 1'b0}};
  logic [7:0]  raddr [5] = '{REG_CTRL, REG_ON_VAL, REG_OFF_VAL,
                             REG_ON_DLY, REG_OFF_DLY};
  logic [31:0] rdef [5] = '{32'h1000, THR_RST, THR_RST, 32'h0, 32'h0};

  sfc_switch_ctrl #(.TICK_CYCLES(4)) DUT (
    .clk_i(clk_i), .rstn_i(rstn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pstrb_i(4'hf), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o),
    .diag_alarm_i(ins[4]), .diag_warn_i(ins[3]), .error_i(ins[2]),
    .ad_sw1_i(ins[1]), .ad_sw2_i(ins[0]), .pv_valid_i(pv_valid_i),
    .pv_id_i(pv_id_i), .pv_value_i(pv_value_i),
    .switch_closed_o(switch_closed_o));
  sfc_load_model load (
    .clk_i(clk_i), .rstn_i(rstn_i), .contact_closed_i(switch_closed_o),
    .load_on_o(load_on), .close_cnt_o(close_cnt));

  // 20 MHz clock
  initial begin
    forever #25 clk_i = ~clk_i;
  end
  // Hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : end_of_test

  task automatic chk_word(string nm, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word

  task automatic chk_bit(string nm, logic e, logic g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  // One APB transfer, held until pready is seen at an edge
  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    @(posedge clk_i);
    while (pready_o !== 1'b1) begin
      @(posedge clk_i);
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : xfer

  // One sample pulse, then time for the result to reach the pin
  task automatic sample(logic [3:0] id, logic [31:0] v, int w);
    @(posedge clk_i);
    pv_valid_i <= 1'b1;
    pv_id_i    <= id;
    pv_value_i <= v;
    @(posedge clk_i);
    pv_valid_i <= 1'b0;
    repeat (w) @(posedge clk_i);
  endtask : sample

  task automatic wait_sw(logic e);
    int n;
    n = 0;
    while (switch_closed_o !== e && n < 60) begin
      @(posedge clk_i);
      n++;
    end
    chk_bit("delayed switch", e, switch_closed_o);
  endtask : wait_sw

  // Main sequence
  initial begin
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    chk_bit("reset switch", 1'b0, switch_closed_o);
    for (int i = 0; i < 5; i++) begin
      xfer(1'b0, raddr[i], 32'h0);
      chk_word("reset value", rdef[i], rd);
    end
    $display("test reset done");
    foreach (rows[i]) begin
      xfer(1'b1, REG_CTRL, rows[i].ctrl);
      ins <= rows[i].ins;
      repeat (4) @(posedge clk_i);
      chk_bit("switch", rows[i].exp, switch_closed_o);
      chk_bit("load", rows[i].exp, load_on);
      xfer(1'b0, REG_STATUS, 32'h0);
      chk_bit("status", rows[i].exp, rd[STAT_SW_BIT]);
    end
    $display("test modes done");
    ins <= 5'h00;
    xfer(1'b1, REG_CTRL, 32'h1103);
    foreach (lrows[i]) begin
      xfer(1'b1, REG_ON_VAL, lrows[i].on);
      xfer(1'b1, REG_OFF_VAL, lrows[i].off);
      sample(lrows[i].id, lrows[i].v, 4);
      chk_bit("limit", lrows[i].exp, switch_closed_o);
    end
    $display("test limits done");
    xfer(1'b1, REG_ON_VAL, 32'h40a00000);
    xfer(1'b1, REG_OFF_VAL, 32'h3f800000);
    xfer(1'b1, REG_ON_DLY, 32'h3);
    sample(4'h1, 32'h40c00000, 8);
    chk_bit("on delay", 1'b0, switch_closed_o);
    wait_sw(1'b1);
    xfer(1'b1, REG_OFF_DLY, 32'h2);
    sample(4'h1, 32'h3f000000, 5);
    chk_bit("off delay", 1'b1, switch_closed_o);
    wait_sw(1'b0);
    cnt0 = close_cnt;
    sample(4'h1, 32'h40c00000, 0);
    sample(4'h1, 32'h3f000000, 40);
    chk_bit("revert", 1'b0, switch_closed_o);
    chk_word("closures", {24'h0, cnt0}, {24'h0, close_cnt});
    $display("test delays done");
    xfer(1'b1, REG_ON_DLY, 32'h7d0);
    xfer(1'b0, REG_ON_DLY, 32'h0);
    chk_word("clamp", 32'h3e8, rd);
    xfer(1'b0, 8'h18, 32'h0);
    chk_bit("unmapped err", 1'b1, err);
    chk_word("unmapped data", 32'h0, rd);
    xfer(1'b1, REG_STATUS, 32'hf);
    chk_bit("status write err", 1'b0, err);
    xfer(1'b1, REG_CTRL, 32'h1001);
    @(posedge clk_i);
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    chk_bit("rereset switch", 1'b0, switch_closed_o);
    xfer(1'b0, REG_CTRL, 32'h0);
    chk_word("rereset ctrl", 32'h1000, rd);
    $display("test registers done");
    end_of_test();
  end
endmodule : sfc_switch_ctrl_tb
